// [rtl/csd_top.sv]
// Chip-select pin assignment, base decode and APB register file.
`timescale 1ns/1ps
module csd_top #(
  parameter int NUM_PINS = 12
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Reset straps from pins
  input  wire logic [1:0]  mode_pins,
  input  wire logic [15:0] data_pins,
  // Internal bus cycle
  input  wire logic        bus_cycle,
  input  wire logic [23:0] bus_addr,
  input  wire logic        bus_read,
  input  wire logic        bus_word,
  input  wire logic        bus_cpu_space,
  input  wire logic        bus_super,
  input  wire logic        bus_program,
  input  wire logic        internal_hit,
  input  wire logic        e_clk_in,
  // Pin drive
  output logic [11:0]      pin_level,
  output logic [11:0]      pin_alt,
  output logic [11:0]      pin_cs_n
);

  //=====================================================================
  // Elaboration check
  if (NUM_PINS != csd_pkg::NUM_PINS) begin : g_bad
    $error("csd_top supports exactly twelve select pins.");
  end

  //=====================================================================
  // Pin synchronisers
  logic [1:0]  mode_s1_ff;
  logic [1:0]  mode_s2_ff;
  logic [15:0] data_s1_ff;
  logic [15:0] data_s2_ff;

  always_ff @(posedge mclk) begin
    mode_s1_ff <= mode_pins;
    mode_s2_ff <= mode_s1_ff;
    data_s1_ff <= data_pins;
    data_s2_ff <= data_s1_ff;
  end

  //=====================================================================
  // Register storage
  logic [15:0] pin_low_ff;
  logic [15:0] pin_high_ff;
  logic [6:0]  dout_ff;
  logic [15:0] base_ff [NUM_PINS];
  logic [15:0] opt_ff  [NUM_PINS];
  logic        pready_ff;
  logic [31:0] prdata_ff;
  logic        pslverr_ff;
  logic [11:0] pin_level_ff;
  logic [11:0] pin_alt_ff;
  logic [11:0] pin_cs_n_ff;

  logic [15:0] nxt_pin_low;
  logic [15:0] nxt_pin_high;
  csd_pkg::csd_mode_t mode;

  assign mode = csd_pkg::csd_mode_t'(mode_s2_ff);

  always_comb begin
    case (mode)
      csd_pkg::MODE_SINGLE: begin
        nxt_pin_low  = csd_pkg::PIN_LOW_SINGLE;
        nxt_pin_high = csd_pkg::PIN_HIGH_SINGLE;
      end
      csd_pkg::MODE_PARTIAL: begin
        nxt_pin_low  = csd_pkg::PIN_LOW_PART;
        nxt_pin_high = csd_pkg::PIN_HIGH_PART;
      end
      csd_pkg::MODE_FULL: begin
        nxt_pin_low  = csd_pkg::PIN_LOW_FULL;
        nxt_pin_low[13] = data_s2_ff[2];
        nxt_pin_low[9]  = data_s2_ff[2];
        nxt_pin_low[7]  = data_s2_ff[10];
        nxt_pin_low[5]  = data_s2_ff[10];
        nxt_pin_low[3]  = data_s2_ff[2];
        nxt_pin_low[0]  = data_s2_ff[0];
        nxt_pin_high = csd_pkg::PIN_HIGH_FULL;
        nxt_pin_high[9] = data_s2_ff[7];
        nxt_pin_high[7] = data_s2_ff[6];
        nxt_pin_high[5] = data_s2_ff[5];
        nxt_pin_high[3] = data_s2_ff[4];
        nxt_pin_high[1] = data_s2_ff[3];
      end
      default: begin
        nxt_pin_low  = csd_pkg::PIN_LOW_SINGLE;
        nxt_pin_high = csd_pkg::PIN_HIGH_SINGLE;
      end
    endcase
  end

  //=====================================================================
  // APB decode
  logic [11:0] idx;
  logic        is_base;
  logic        is_opt;
  logic [3:0]  sel_num;
  logic        mapped;
  logic        wr_en;
  logic [15:0] rd_word;
  logic [11:0] rel_base;
  logic [11:0] rel_opt;

  assign idx      = paddr[13:2];
  assign rel_base = idx - csd_pkg::IDX_BASE_0;
  assign rel_opt  = idx - csd_pkg::IDX_OPT_0;
  assign is_base  = (idx >= csd_pkg::IDX_BASE_0) && (idx <= csd_pkg::IDX_BASE_10) &&
                    (rel_base[1:0] == 2'h0);
  assign is_opt   = (idx >= csd_pkg::IDX_OPT_0) && (rel_opt <= 12'h028) &&
                    (rel_opt[1:0] == 2'h0);

  always_comb begin
    sel_num = 4'h0;
    if (is_base) begin
      sel_num = rel_base[5:2] + 4'h1;
    end else if (is_opt) begin
      sel_num = rel_opt[5:2] + 4'h1;
    end
  end

  always_comb begin
    mapped  = 1'b1;
    rd_word = 16'h0000;
    if (paddr[1:0] != 2'h0) begin
      mapped = 1'b0;
    end else if (idx == csd_pkg::IDX_PIN_LOW) begin
      rd_word = pin_low_ff & csd_pkg::PIN_LOW_MASK;
    end else if (idx == csd_pkg::IDX_PIN_HIGH) begin
      rd_word = pin_high_ff & csd_pkg::PIN_HIGH_MASK;
    end else if (idx == csd_pkg::IDX_DOUT) begin
      rd_word = {9'h000, dout_ff};
    end else if (idx == csd_pkg::IDX_BOOT_BASE) begin
      rd_word = base_ff[0];
    end else if (idx == csd_pkg::IDX_BOOT_OPT) begin
      rd_word = opt_ff[0];
    end else if (is_base) begin
      rd_word = base_ff[sel_num];
    end else if (is_opt) begin
      rd_word = opt_ff[sel_num];
    end else begin
      mapped = 1'b0;
    end
  end

  assign wr_en = psel && penable && pready_ff && pwrite && mapped;

  // One wait-free access cycle: answer is prepared in setup, given in access.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= psel && !penable;
      pslverr_ff <= psel && !penable && !mapped;
      if (psel && !penable) begin
        prdata_ff <= (pwrite || !mapped) ? 32'h0000_0000 : {16'h0000, rd_word};
      end
    end
  end

  //=====================================================================
  // Register writes
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pin_low_ff  <= nxt_pin_low;
      pin_high_ff <= nxt_pin_high;
    end else if (wr_en && idx == csd_pkg::IDX_PIN_LOW) begin
      pin_low_ff <= pwdata[15:0] & csd_pkg::PIN_LOW_MASK;
    end else if (wr_en && idx == csd_pkg::IDX_PIN_HIGH) begin
      pin_high_ff <= pwdata[15:0] & csd_pkg::PIN_HIGH_MASK;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dout_ff <= csd_pkg::DOUT_RST;
    end else if (wr_en && idx == csd_pkg::IDX_DOUT) begin
      dout_ff <= pwdata[6:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      base_ff[0] <= csd_pkg::BOOT_BASE_RST;
      opt_ff[0]  <= csd_pkg::BOOT_OPT_RST;
      for (int i = 1; i < NUM_PINS; i++) begin
        base_ff[i] <= csd_pkg::BASE_RST;
        opt_ff[i]  <= csd_pkg::OPT_RST;
      end
    end else if (wr_en) begin
      if (idx == csd_pkg::IDX_BOOT_BASE) begin
        base_ff[0] <= pwdata[15:0];
      end else if (idx == csd_pkg::IDX_BOOT_OPT) begin
        opt_ff[0] <= pwdata[15:0];
      end else if (is_base) begin
        base_ff[sel_num] <= pwdata[15:0];
      end else if (is_opt) begin
        opt_ff[sel_num] <= pwdata[15:0];
      end
    end
  end

  //=====================================================================
  // Pin fields
  logic [1:0] fld [NUM_PINS];

  always_comb begin
    for (int p = 0; p < 7; p++) begin
      fld[p] = pin_low_ff[2*p +: 2];
    end
    fld[csd_pkg::PIN_FC1] = {1'b0, pin_low_ff[csd_pkg::FC1_BIT]};
    fld[6] = pin_low_ff[13:12];
    for (int p = 7; p < NUM_PINS; p++) begin
      fld[p] = pin_high_ff[2*(p-7) +: 2];
    end
  end

  //=====================================================================
  // Select comparators
  logic [11:0] hit;

  for (genvar g = 0; g < NUM_PINS; g++) begin : g_sel
    csd_match u_match (
      .base          (base_ff[g]),
      .opt           (opt_ff[g]),
      .field         (fld[g]),
      .bus_cycle     (bus_cycle),
      .bus_addr      (bus_addr),
      .bus_read      (bus_read),
      .bus_word      (bus_word),
      .bus_cpu_space (bus_cpu_space),
      .bus_super     (bus_super),
      .bus_program   (bus_program),
      .internal_hit  (internal_hit),
      .hit           (hit[g])
    );
  end

  //=====================================================================
  // Pin drive
  // Outputs lag the bus by one clock; the cost buys glitch-free selects.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pin_cs_n_ff <= 12'hFFF;
    end else begin
      pin_cs_n_ff <= ~hit;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pin_level_ff <= 12'hFFF;
      pin_alt_ff   <= 12'h000;
    end else begin
      for (int p = 0; p < NUM_PINS; p++) begin
        pin_alt_ff[p] <= (fld[p] == csd_pkg::FLD_ALT);
        case (fld[p])
          csd_pkg::FLD_DOUT: begin
            if (p == csd_pkg::PIN_TOP) begin
              pin_level_ff[p] <= e_clk_in;
            end else if (p >= csd_pkg::PIN_DOUT_LO) begin
              pin_level_ff[p] <= dout_ff[p-csd_pkg::PIN_DOUT_LO];
            end else begin
              pin_level_ff[p] <= 1'b1;
            end
          end
          csd_pkg::FLD_ALT: pin_level_ff[p] <= 1'b1;
          default:          pin_level_ff[p] <= ~hit[p];
        endcase
      end
    end
  end

  assign pready    = pready_ff;
  assign prdata    = prdata_ff;
  assign pslverr   = pslverr_ff;
  assign pin_level = pin_level_ff;
  assign pin_alt   = pin_alt_ff;
  assign pin_cs_n  = pin_cs_n_ff;

endmodule

// [pkg/csd_pkg.sv]
// Shared constants and decode helpers for the chip-select pin and base decode block.
//=====================================================================
// Functional notes
// - Unused pin-assign high bits read zero
// - Low bit 10 picks function-code-one or output
// - Select-ten field 00 drives bus clock
// - Field: output, alternate, 8-bit, 16-bit select
// - Discrete pin drives its latch bit
// - Bus arbitration pins have no discrete output
// - Top address pin gives bus clock, not data
// - Output or alternate field blocks select decode
// - 8-bit select asserts across whole block
// - 16-bit select follows byte lane option
// - Internal module claim suppresses the select
// - Address bits 23:20 must equal bit 19
// - Size code picks lowest compared address bit
// - Base bits 15:3 address, 2:0 size
// - Each select owns a base register
// - Select asserts low on full match only
// - Pin-assign reset follows mode and data straps
// - Discrete latch holds software-written levels
package csd_pkg;

  //=====================================================================
  // Register indices; byte address is four times the index.
  localparam logic [11:0] IDX_PIN_LOW   = 12'hA44;
  localparam logic [11:0] IDX_PIN_HIGH  = 12'hA46;
  localparam logic [11:0] IDX_BOOT_BASE = 12'hA48;
  localparam logic [11:0] IDX_BOOT_OPT  = 12'hA4A;
  localparam logic [11:0] IDX_BASE_0    = 12'hA4C;
  localparam logic [11:0] IDX_OPT_0     = 12'hA4E;
  localparam logic [11:0] IDX_BASE_10   = 12'hA74;
  localparam logic [11:0] IDX_DOUT      = 12'hA40;

  //=====================================================================
  // Writable masks and reset values.
  localparam logic [15:0] PIN_LOW_MASK    = 16'h37FF;
  localparam logic [15:0] PIN_HIGH_MASK   = 16'h03FF;
  localparam logic [15:0] PIN_LOW_SINGLE  = 16'h005F;
  localparam logic [15:0] PIN_LOW_PART    = 16'h265A;
  localparam logic [15:0] PIN_LOW_FULL    = 16'h1556;
  localparam logic [15:0] PIN_HIGH_SINGLE = 16'h0300;
  localparam logic [15:0] PIN_HIGH_PART   = 16'h02AA;
  localparam logic [15:0] PIN_HIGH_FULL   = 16'h0155;
  localparam logic [15:0] BOOT_BASE_RST   = 16'h0007;
  localparam logic [15:0] BOOT_OPT_RST    = 16'h7B70;
  localparam logic [15:0] BASE_RST        = 16'h0000;
  localparam logic [15:0] OPT_RST         = 16'h0000;
  localparam logic [6:0]  DOUT_RST        = 7'h00;

  //=====================================================================
  // Field positions.
  localparam int FC1_BIT     = 10;
  localparam int BASE_LSB    = 3;
  localparam int OPT_BYTE_LO = 13;
  localparam int OPT_RW_LO   = 11;
  localparam int OPT_SPC_LO  = 4;
  localparam int OPT_IPL_LO  = 1;
  localparam int NUM_PINS    = 12;
  localparam int PIN_FC1     = 5;
  localparam int PIN_TOP     = 11;
  localparam int PIN_DOUT_LO = 4;

  //=====================================================================
  // Modes and pin field codes.
  typedef enum logic [1:0] {
    MODE_SINGLE,
    MODE_PARTIAL,
    MODE_FULL,
    MODE_RSVD
  } csd_mode_t;

  localparam logic [1:0] FLD_DOUT = 2'h0;
  localparam logic [1:0] FLD_ALT  = 2'h1;
  localparam logic [1:0] FLD_CS8  = 2'h2;
  localparam logic [1:0] FLD_CS16 = 2'h3;

  // Lowest compared address bit, counted from address bit 11.
  function automatic logic [3:0] blk_low(input logic [2:0] code);
    case (code)
      3'h0:    blk_low = 4'h0;
      3'h1:    blk_low = 4'h2;
      3'h2:    blk_low = 4'h3;
      3'h3:    blk_low = 4'h5;
      3'h4:    blk_low = 4'h6;
      3'h5:    blk_low = 4'h7;
      3'h6:    blk_low = 4'h8;
      default: blk_low = 4'h9;
    endcase
  endfunction

endpackage

// [rtl/csd_match.sv]
// Per-select address and option comparator.
`timescale 1ns/1ps
module csd_match (
  // Select programming
  input  wire logic [15:0] base,
  input  wire logic [15:0] opt,
  input  wire logic [1:0]  field,
  // Bus cycle
  input  wire logic        bus_cycle,
  input  wire logic [23:0] bus_addr,
  input  wire logic        bus_read,
  input  wire logic        bus_word,
  input  wire logic        bus_cpu_space,
  input  wire logic        bus_super,
  input  wire logic        bus_program,
  input  wire logic        internal_hit,
  // Result
  output logic             hit
);

  logic [12:0] diff;
  logic [3:0]  low;
  logic        in_blk;
  logic        hi_ok;
  logic        rw_ok;
  logic        spc_ok;
  logic        lane_ok;
  logic [1:0]  byte_f;
  logic [1:0]  rw_f;
  logic [1:0]  spc_f;
  logic [2:0]  ipl_f;

  assign byte_f = opt[csd_pkg::OPT_BYTE_LO +: 2];
  assign rw_f   = opt[csd_pkg::OPT_RW_LO +: 2];
  assign spc_f  = opt[csd_pkg::OPT_SPC_LO +: 2];
  assign ipl_f  = opt[csd_pkg::OPT_IPL_LO +: 3];
  assign low    = csd_pkg::blk_low(base[2:0]);
  assign diff   = base[15:csd_pkg::BASE_LSB] ^ bus_addr[23:11];

  always_comb begin
    in_blk = 1'b1;
    for (int i = 0; i < 13; i++) begin
      if (i >= int'(low) && diff[i]) begin
        in_blk = 1'b0;
      end
    end
  end

  assign hi_ok = (bus_addr[23:20] == {4{bus_addr[19]}});
  assign rw_ok = bus_read ? rw_f[0] : rw_f[1];

  always_comb begin
    case (spc_f)
      2'h0:    spc_ok = bus_cpu_space && (ipl_f == 3'h0 || ipl_f == bus_addr[3:1]);
      2'h1:    spc_ok = !bus_cpu_space && !bus_super;
      2'h2:    spc_ok = !bus_cpu_space && bus_super;
      default: spc_ok = !bus_cpu_space;
    endcase
    if (spc_f != 2'h0) begin
      case (ipl_f)
        3'h0:      spc_ok = spc_ok;
        3'h1, 3'h5: spc_ok = spc_ok && !bus_program;
        3'h2, 3'h6: spc_ok = spc_ok && bus_program;
        default:   spc_ok = 1'b0;
      endcase
    end
  end

  always_comb begin
    case (field)
      csd_pkg::FLD_CS8:  lane_ok = 1'b1;
      csd_pkg::FLD_CS16: lane_ok = (byte_f[1] && (bus_word || !bus_addr[0])) ||
                                   (byte_f[0] && (bus_word || bus_addr[0]));
      default:           lane_ok = 1'b0;
    endcase
  end

  assign hit = bus_cycle && field[1] && in_blk && hi_ok && rw_ok && spc_ok && lane_ok &&
               !internal_hit;

endmodule

// [dv/csd_top_sva.sv]
// Port-level checker for the chip-select pin and base decode block.
`timescale 1ns/1ps
module csd_top_sva #(
  parameter int NUM_PINS = 12
) (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst_n,
  // APB slave
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // Bus cycle
  input wire logic        bus_cycle,
  input wire logic [23:0] bus_addr,
  input wire logic        internal_hit,
  // Pin drive
  input wire logic [11:0] pin_level,
  input wire logic [11:0] pin_alt,
  input wire logic [11:0] pin_cs_n
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  //=====================================================================
  // Sequences
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_upper_bad;
    bus_addr[23:20] != {4{bus_addr[19]}};
  endsequence

  //=====================================================================
  // Register bus
  a_ready_after_setup: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_ready_needs_access: assert property (pready |-> (psel && penable))
    else $error("ready outside access phase");
  a_upper_read_zero: assert property (pready |-> (prdata[31:16] == 16'h0000))
    else $error("upper read data not zero");
  a_refused_reads_zero: assert property ((pready && pslverr && !pwrite) |-> (prdata == 32'h0))
    else $error("refused read returned data");

  //=====================================================================
  // Select decode
  a_cs_needs_cycle: assert property ((pin_cs_n != 12'hFFF) |-> $past(bus_cycle))
    else $error("select low without a bus cycle");
  a_internal_wins: assert property (internal_hit |=> (pin_cs_n == 12'hFFF))
    else $error("select asserted on internal claim");
  a_upper_addr_match: assert property (s_upper_bad |=> (pin_cs_n == 12'hFFF))
    else $error("select asserted with upper address mismatch");
  a_fc1_no_select: assert property (pin_cs_n[5])
    else $error("function code pin asserted a select");
  a_select_drives_low: assert property (((pin_level | pin_alt) & ~pin_cs_n) == 12'h000)
    else $error("asserted select not driven low");
endmodule

bind csd_top csd_top_sva #(.NUM_PINS(NUM_PINS)) u_sva (
  .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .bus_cycle(bus_cycle),
  .bus_addr(bus_addr), .internal_hit(internal_hit), .pin_level(pin_level),
  .pin_alt(pin_alt), .pin_cs_n(pin_cs_n)
);

// [dv/csd_ext_dev.sv]
// Behavioural external device that logs which select pin addressed it.
`timescale 1ns/1ps
module csd_ext_dev (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Select pins
  input  wire logic [11:0] pin_cs_n,
  // Observation
  output logic [3:0]       last_pin_ff
);
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      last_pin_ff <= 4'hF;
    end else begin
      for (int i = 0; i < 12; i++) begin
        if (!pin_cs_n[i]) begin
          last_pin_ff <= 4'(i);
        end
      end
    end
  end
endmodule

// [dv/csd_top_tb_top.sv]
// Self-checking testbench for the chip-select pin and base decode block.
`timescale 1ns/1ps
module csd_top_tb_top;
  logic        mclk;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic [1:0]  mode_pins = 2'h0;
  logic [15:0] data_pins = 16'h0000;
  logic        bus_cycle = 1'b0;
  logic [23:0] bus_addr = 24'h0;
  logic        bus_read = 1'b1;
  logic        bus_super = 1'b1;
  logic        bus_word = 1'b0;
  logic        bus_cpu_space = 1'b0;
  logic        bus_program = 1'b0;
  logic        internal_hit = 1'b0;
  logic        e_clk_in = 1'b0;
  logic [11:0] pin_level;
  logic [11:0] pin_alt;
  logic [11:0] pin_cs_n;
  logic [3:0]  last_pin;
  logic [31:0] rd;
  logic        err;
  int          n_errors = 0;
  int          checks = 0;
  localparam logic [11:0] BASE3 = csd_pkg::IDX_BASE_0 + 12'h00C;
  localparam logic [11:0] OPT3  = csd_pkg::IDX_OPT_0 + 12'h00C;
  logic [1:0]  rm  [5] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h3};
  logic [15:0] rdp [5] = '{16'h0000, 16'h0000, 16'h0000, 16'hFFFF, 16'h0000};
  logic [15:0] rlo [5] = '{16'h005F, 16'h265A, 16'h1556, 16'h37FF, 16'h005F};
  logic [15:0] rhi [5] = '{16'h0300, 16'h02AA, 16'h0155, 16'h03FF, 16'h0300};
  logic [23:0] blk [8] = '{24'h000800, 24'h002000, 24'h004000, 24'h010000,
                           24'h020000, 24'h040000, 24'h080000, 24'h080000};

  csd_top uut (
    .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .mode_pins(mode_pins), .data_pins(data_pins), .bus_cycle(bus_cycle),
    .bus_addr(bus_addr), .bus_read(bus_read), .bus_word(bus_word), .bus_cpu_space(bus_cpu_space),
    .bus_super(bus_super), .bus_program(bus_program), .internal_hit(internal_hit),
    .e_clk_in(e_clk_in), .pin_level(pin_level), .pin_alt(pin_alt), .pin_cs_n(pin_cs_n)
  );
  csd_ext_dev u_dev (.mclk(mclk), .rst_n(rst_n), .pin_cs_n(pin_cs_n), .last_pin_ff(last_pin));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  //=====================================================================
  // Tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (n_errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // The request is held until pready is seen high, so a slow slave is tolerated.
  task automatic apb(input logic wr, input logic [11:0] idx, input logic [15:0] d);
    @(posedge mclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= {2'b00, idx, 2'b00};
    pwdata <= {16'h0000, d};
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] idx, input logic [15:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rchk(input logic [11:0] idx, input logic [15:0] exp);
    apb(1'b0, idx, 16'h0000);
    check(rd, {16'h0000, exp});
  endtask

  task automatic do_reset(input logic [1:0] m, input logic [15:0] d);
    rst_n     <= 1'b0;
    mode_pins <= m;
    data_pins <= d;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
  endtask

  // Probes select three on one bus cycle, held one more clock after the check before bus_cycle drops.
  task automatic probe(input logic [23:0] a, input logic rdn, input logic sup,
                       input logic ih, input logic ex);
    @(posedge mclk);
    bus_cycle    <= 1'b1;
    bus_addr     <= a;
    bus_read     <= rdn;
    bus_super    <= sup;
    internal_hit <= ih;
    @(posedge mclk);
    #1;
    check({31'h0, pin_cs_n[4]}, {31'h0, ex});
    @(posedge mclk);
    bus_cycle <= 1'b0;
  endtask

  //=====================================================================
  // Tests
  initial begin
    for (int i = 0; i < 5; i++) begin
      do_reset(rm[i], rdp[i]);
      rchk(csd_pkg::IDX_PIN_LOW, rlo[i]);
      rchk(csd_pkg::IDX_PIN_HIGH, rhi[i]);
    end
    rchk(csd_pkg::IDX_BOOT_BASE, 16'h0007);
    rchk(csd_pkg::IDX_BOOT_OPT, 16'h7B70);
    rchk(csd_pkg::IDX_BASE_10, 16'h0000);
    rchk(OPT3, 16'h0000);
    rchk(csd_pkg::IDX_DOUT, 16'h0000);
    apb(1'b0, 12'h000, 16'h0000);
    check(rd, 32'h0);
    check({31'h0, err}, 32'h1);
    wr(csd_pkg::IDX_PIN_LOW, 16'hFFFF);
    rchk(csd_pkg::IDX_PIN_LOW, 16'h37FF);
    wr(csd_pkg::IDX_PIN_HIGH, 16'hFFFF);
    rchk(csd_pkg::IDX_PIN_HIGH, 16'h03FF);
    wr(csd_pkg::IDX_PIN_LOW, 16'h0000);
    wr(csd_pkg::IDX_PIN_HIGH, 16'h0000);
    wr(csd_pkg::IDX_DOUT, 16'h0055);
    e_clk_in <= 1'b1;
    rchk(csd_pkg::IDX_DOUT, 16'h0055);
    check({8'h0, pin_alt, pin_level}, 32'h0000_0D5F);
    wr(csd_pkg::IDX_DOUT, 16'h002A);
    e_clk_in <= 1'b0;
    rchk(csd_pkg::IDX_DOUT, 16'h002A);
    check({8'h0, pin_alt, pin_level}, 32'h0000_02AF);
    wr(csd_pkg::IDX_PIN_LOW, 16'h0400);
    wr(csd_pkg::IDX_PIN_HIGH, 16'h0155);
    rchk(csd_pkg::IDX_PIN_HIGH, 16'h0155);
    check({8'h0, pin_alt, pin_level}, 32'h00FA_0FAF);
    wr(csd_pkg::IDX_PIN_LOW, 16'h0200);
    wr(BASE3, 16'h0400);
    wr(OPT3, 16'h1830);
    probe(24'h040000, 1'b1, 1'b1, 1'b0, 1'b0);
    probe(24'h0407FF, 1'b1, 1'b1, 1'b0, 1'b0);
    check({28'h0, last_pin}, 32'h4);
    probe(24'h040800, 1'b1, 1'b1, 1'b0, 1'b1);
    probe(24'h03FFFF, 1'b1, 1'b1, 1'b0, 1'b1);
    probe(24'h040000, 1'b1, 1'b1, 1'b1, 1'b1);
    probe(24'h040000, 1'b0, 1'b1, 1'b0, 1'b0);
    wr(OPT3, 16'h0830);
    probe(24'h040000, 1'b0, 1'b1, 1'b0, 1'b1);
    wr(OPT3, 16'h1810);
    probe(24'h040000, 1'b1, 1'b1, 1'b0, 1'b1);
    probe(24'h040000, 1'b1, 1'b0, 1'b0, 1'b0);
    wr(OPT3, 16'h1830);
    for (int k = 0; k < 8; k++) begin
      // A zero base is aligned to every block size.
      wr(BASE3, {13'h0000, 3'(k)});
      probe(blk[k] - 24'h1, 1'b1, 1'b1, 1'b0, 1'b0);
      probe(blk[k], 1'b1, 1'b1, 1'b0, 1'b1);
    end
    wr(csd_pkg::IDX_PIN_LOW, 16'h0100);
    probe(24'h000000, 1'b1, 1'b1, 1'b0, 1'b1);
    wr(csd_pkg::IDX_PIN_LOW, 16'h0300);
    for (int b = 0; b < 4; b++) begin
      wr(OPT3, {1'b0, 2'(b), 13'h1830});
      probe(24'h000000, 1'b1, 1'b1, 1'b0, ~b[1]);
      probe(24'h000001, 1'b1, 1'b1, 1'b0, ~b[0]);
    end
    // A word transfer reaches the upper lane even at an odd address.
    wr(OPT3, 16'h5830);
    probe(24'h000001, 1'b1, 1'b1, 1'b0, 1'b1);
    bus_word <= 1'b1;
    probe(24'h000001, 1'b1, 1'b1, 1'b0, 1'b0);
    bus_word <= 1'b0;
    wr(csd_pkg::IDX_PIN_LOW, 16'h0200);
    wr(OPT3, 16'h1806);
    bus_cpu_space <= 1'b1;
    probe(24'h000006, 1'b1, 1'b1, 1'b0, 1'b0);
    probe(24'h000004, 1'b1, 1'b1, 1'b0, 1'b1);
    bus_cpu_space <= 1'b0;
    wr(OPT3, 16'h1834);
    probe(24'h000000, 1'b1, 1'b1, 1'b0, 1'b1);
    bus_program <= 1'b1;
    probe(24'h000000, 1'b1, 1'b1, 1'b0, 1'b0);
    bus_program <= 1'b0;
    tally_and_finish();
  end

  initial begin
    repeat (5000) @(posedge mclk);
    n_errors++;
    tally_and_finish();
  end
endmodule
